// ==== src/scm_device.sv ====
// Read-out end of a serial configuration memory streaming its bit program.
// Assumes the FPGA end drives the control pins; all pins are synchronised here.
//
// Overview of operation
// - Selected and gated: clock advances, driver on
// - Deselected: counters stop, low-power standby
// - Programming mode ignores chain select
// - Chain-pass low once the stream has ended
// - Chain-pass follows select until reset, then high
// - Program-select enables only in programming mode
// - Ready pulled low during power-on reset
// - Host holds mode select high while loading
// - Mode select low enters programming mode
// - Clock after last bit: chain-pass, driver off
// - Downstream enables on low chain select
// - Reset at end clears address counter
// - Host holds gate inactive to keep counters
// - Stored polarity of reset/gate input
// - Standby keeps data output high impedance
// - FPGA supplies clock, takes serial data
// - Active gate clears counters; inactive enables
// - Power-up resets address counter
// - Reset state clears counter, tri-states output
`timescale 1ns/1ns
module scm_device import scm_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   scm_if.dev link,
   input wire logic prog_wr,
   input wire logic [BYTE_W-1:0] prog_addr,
   input wire logic [7:0] prog_data,
   input wire logic pol_wr,
   input wire logic pol_val,
   output logic [BYTE_W-1:0] byte_addr,
   output logic [BIT_W-1:0] bit_addr,
   output logic standby,
   output logic prog_mode,
   output logic reset_pol
);
   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [4:0] pins_s;
   logic fpga_config_clock_d;
   logic last_out;
   logic ended;
   logic ready_done;
   logic [7:0] por_cnt;
   logic [7:0] mem [MEM_BYTES];

   // Idle levels at reset match what the host drives in its own reset, so
   // no false clock edge or programming mode shows while the stages fill;
   // program-select idles low, as an unconnected pin would
   scm_sync #(.W(5)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({link.fpga_config_clock, link.chain_select_n, link.reset_oe,
          link.program_mode_select_n, link.program_select_pin}),
      .init(5'h0e),
      .q(pins_s)
   );

   wire fpga_config_clock_s = pins_s[4];
   wire ce_n_s = pins_s[3];
   wire gate_s = pins_s[2];
   wire mode_n_s = pins_s[1];
   wire psel_s = pins_s[0];

   // Edge seen from the synchronised clock, never from the first stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fpga_config_clock_d <= 1'b0;
      end else begin
         fpga_config_clock_d <= fpga_config_clock_s;
      end
   end

   // ----------------------------------------------------------------
   // Decode of the control pins
   // ----------------------------------------------------------------
   // Polarity 0 resets on a low gate, polarity 1 on a high gate
   wire rst_act = reset_pol ? gate_s : ~gate_s;
   // Counters held in reset until the power-on cycle ends
   wire clr = rst_act | ~ready_done;
   // Mode select low is programming; chain select plays no part there
   wire read_mode = mode_n_s;
   // Rising edge of the synchronised clock; each pin phase must last at
   // least two system clocks or an edge can be missed
   wire fpga_config_clock_rise = fpga_config_clock_s & ~fpga_config_clock_d;
   // Selected, gated and in read mode: a clock edge steps the stream
   wire read_step = fpga_config_clock_rise & ~ce_n_s & read_mode & ~clr;
   // Programming writes need both programming mode and program-select
   wire prog_ok = ~mode_n_s & psel_s & ready_done;

   // ----------------------------------------------------------------
   // Address and bit counter
   // ----------------------------------------------------------------
   wire [ADDR_W-1:0] addr = {byte_addr, bit_addr};
   // End of the stream is the all-ones address; the counter never wraps
   wire at_max = &addr;
   wire [ADDR_W-1:0] addr_inc = addr + 16'h0001;
   wire [7:0] cur_byte = mem[byte_addr];
   // Most significant bit of each stored byte goes out first
   wire cur_bit = cur_byte[~bit_addr];
   wire step_bit = read_step & ~last_out;

   wire [ADDR_W-1:0] next_addr = clr ? ADDR_RESET :
                                 (step_bit & ~at_max) ? addr_inc : addr;
   wire next_last = clr ? 1'b0 : (step_bit & at_max) ? 1'b1 : last_out;
   // The edge after the final bit ends the stream
   wire next_ended = clr ? 1'b0 : (read_step & last_out) ? 1'b1 : ended;

   // Driver on only when gated, selected, reading and not past the end
   wire next_drive = ~clr & read_mode & ~ce_n_s & ~next_ended;

   // Chain-pass follows chain select after the end until a reset
   wire next_pass_n = (next_ended & read_mode) ? ce_n_s : 1'b1;

   // Counter, end flags and serial bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         byte_addr <= '0;
         bit_addr <= '0;
         last_out <= 1'b0;
         ended <= 1'b0;
         link.data_o <= 1'b1;
      end else begin
         byte_addr <= next_addr[ADDR_W-1:BIT_W];
         bit_addr <= next_addr[BIT_W-1:0];
         last_out <= next_last;
         ended <= next_ended;
         if (step_bit) begin
            link.data_o <= cur_bit;
         end
      end
   end

   // Pin drivers; the enables are active low
   // Enable and chain-pass switch on one edge, so chained drivers never overlap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.data_oe_n <= 1'b1;
         link.chain_pass_n <= 1'b1;
      end else begin
         link.data_oe_n <= ~next_drive;
         link.chain_pass_n <= next_pass_n;
      end
   end

   // ----------------------------------------------------------------
   // Power-on reset cycle and ready indicator
   // ----------------------------------------------------------------
   // Counters stay cleared until this count ends; the host waits on the line
   wire por_end = (por_cnt == 8'(POR_CYC - 1));

   // Open-collector: low is driven, high is only released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         por_cnt <= 8'h00;
         ready_done <= 1'b0;
         link.ready_o <= 1'b0;
         link.ready_oe_n <= 1'b0;
      end else begin
         if (!ready_done) begin
            por_cnt <= por_cnt + 8'h01;
         end
         if (por_end) begin
            ready_done <= 1'b1;
            link.ready_oe_n <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Stored contents and polarity
   // ----------------------------------------------------------------
   // No reset on the array: it stands for nonvolatile cells
   // Writes land only in programming mode with program-select high
   always_ff @(posedge clk) begin
      if (prog_wr & prog_ok) begin
         mem[prog_addr] <= prog_data;
      end
   end

   // Polarity is nonvolatile in silicon; here it returns to default at reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_pol <= RESET_POL_DEFAULT;
      end else if (pol_wr & prog_ok) begin
         reset_pol <= pol_val;
      end
   end

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   // Standby is a read-mode state only; programming ignores chain select
   wire standby_now = ce_n_s & read_mode;
   wire prog_now = ~mode_n_s;

   // Status flags, registered so every output leaves a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         standby <= 1'b0;
         prog_mode <= 1'b0;
      end else begin
         standby <= standby_now;
         prog_mode <= prog_now;
      end
   end
endmodule

// ==== src/scm_pkg.sv ====
// Constants shared by both ends of the serial configuration memory link.
// Assumes a single 100 MHz system clock on each end.
package scm_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   // Power-on reset length of the memory
   localparam int POR_TIME_NS = 200;
   localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least high time of the reset/output-gate pulse
   localparam int HOE_TIME_NS = 25;
   localparam int HOE_CYC = (HOE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Configuration clock period, well under the 10 MHz limit
   localparam int FPGA_CONFIG_CLOCK_PERIOD_NS = 200;
   localparam int FPGA_CONFIG_CLOCK_HALF_CYC = FPGA_CONFIG_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Memory geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 13;
   localparam int BIT_W = 3;
   localparam int MEM_BYTES = 8192;
   localparam int LEN_W = ADDR_W + 1;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   // Polarity 0: reset when the gate input is low, gate open when high
   localparam logic RESET_POL_DEFAULT = 1'h0;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
endpackage

// ==== src/scm_if.sv ====
// Pins between the configuration memory and the FPGA configuration logic.
// Assumes both ends drive only enables for shared lines; pull-ups are modelled here.
`timescale 1ns/1ns
interface scm_if;
   logic fpga_config_clock;
   logic chain_select_n;
   logic reset_oe;
   logic program_mode_select_n;
   logic program_select_pin;
   logic data_o;
   logic data_oe_n;
   logic chain_pass_n;
   logic ready_o;
   logic ready_oe_n;
   logic data_line;
   logic ready_line;

   // ----------------------------------------------------------------
   // Line levels, pulled high when nobody drives
   // ----------------------------------------------------------------
   assign data_line = data_oe_n ? 1'b1 : data_o;
   assign ready_line = ready_oe_n ? 1'b1 : ready_o;

   modport dev (
      input fpga_config_clock,
      input chain_select_n,
      input reset_oe,
      input program_mode_select_n,
      input program_select_pin,
      output data_o,
      output data_oe_n,
      output chain_pass_n,
      output ready_o,
      output ready_oe_n
   );

   modport host (
      output fpga_config_clock,
      output chain_select_n,
      output reset_oe,
      output program_mode_select_n,
      output program_select_pin,
      input data_line,
      input ready_line,
      input chain_pass_n
   );
endinterface

// ==== src/scm_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are quasi-static levels from outside this clock domain.
`timescale 1ns/1ns
module scm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] init,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] held;

   // Stages hold the input relative to its idle level, so reset reads idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         held <= '0;
      end else begin
         meta <= d ^ init;
         held <= meta;
      end
   end

   // Only the second stage is visible to logic
   assign q = held ^ init;
endmodule

// ==== src/scm_host.sv ====
// FPGA configuration end in master serial mode: makes the clock, reads bits.
// Assumes one memory or a chain of them on the link; data line pulled high.
`timescale 1ns/1ns
module scm_host import scm_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   scm_if.host link,
   input wire logic start,
   input wire logic [LEN_W-1:0] load_len,
   input wire logic clear_at_end,
   input wire logic gate_pol,
   input wire logic isp_req,
   output logic rx_bit,
   output logic rx_valid,
   output logic busy,
   output logic done
);
   typedef enum logic [2:0] {H_IDLE, H_WAIT_RDY, H_RESET, H_LOAD, H_END} scm_hstate_e;

   scm_hstate_e state;
   logic [1:0] in_s;
   logic [3:0] div;
   logic [3:0] hcnt;
   logic [LEN_W-1:0] edges;

   // Data idles high on its pull-up, ready low until the memory lets go
   scm_sync #(.W(2)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({link.data_line, link.ready_line}),
      .init(2'h2),
      .q(in_s)
   );

   wire data_s = in_s[1];
   wire ready_s = in_s[0];
   wire half_end = (div == 4'(FPGA_CONFIG_CLOCK_HALF_CYC - 1));
   wire hoe_end = (hcnt == 4'(HOE_CYC - 1));
   wire rise_now = half_end & ~link.fpga_config_clock;
   wire last_edge = (edges == load_len);

   // ----------------------------------------------------------------
   // Load sequencer
   // ----------------------------------------------------------------
   // Bits are sampled just before the next rising edge, so device delay has
   // a full clock period to settle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= H_IDLE;
         div <= 4'h0;
         hcnt <= 4'h0;
         edges <= '0;
         rx_bit <= 1'b0;
         rx_valid <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         link.fpga_config_clock <= 1'b0;
         link.chain_select_n <= 1'b1;
         link.reset_oe <= 1'b1;
         link.program_mode_select_n <= 1'b1;
         link.program_select_pin <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         done <= 1'b0;
         case (state)
            H_IDLE: begin
               busy <= 1'b0;
               // Programming mode only while no load runs
               link.program_mode_select_n <= ~isp_req;
               link.program_select_pin <= isp_req;
               if (start & ~isp_req) begin
                  busy <= 1'b1;
                  link.program_mode_select_n <= 1'b1;
                  link.program_select_pin <= 1'b0;
                  state <= H_WAIT_RDY;
               end
            end
            H_WAIT_RDY: begin
               if (ready_s) begin
                  hcnt <= 4'h0;
                  link.reset_oe <= gate_pol;
                  state <= H_RESET;
               end
            end
            H_RESET: begin
               hcnt <= hcnt + 4'h1;
               if (hoe_end) begin
                  link.reset_oe <= ~gate_pol;
                  link.chain_select_n <= 1'b0;
                  div <= 4'h0;
                  edges <= '0;
                  state <= H_LOAD;
               end
            end
            H_LOAD: begin
               div <= half_end ? 4'h0 : div + 4'h1;
               if (half_end) begin
                  link.fpga_config_clock <= ~link.fpga_config_clock;
               end
               if (rise_now) begin
                  edges <= edges + 17'h0_0001;
                  if (edges != '0) begin
                     rx_bit <= data_s;
                     rx_valid <= 1'b1;
                  end
                  if (last_edge) begin
                     state <= H_END;
                  end
               end
            end
            H_END: begin
               div <= half_end ? 4'h0 : div + 4'h1;
               if (half_end) begin
                  link.fpga_config_clock <= 1'b0;
                  link.chain_select_n <= 1'b1;
                  // Clear the counters or leave them where they stand
                  link.reset_oe <= clear_at_end ? gate_pol : ~gate_pol;
                  done <= 1'b1;
                  busy <= 1'b0;
                  state <= H_IDLE;
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== verification/scm_link_asserts.sv ====
// Concurrent checks on the pins between the memory and the FPGA end.
// Assumes the bench instantiates it beside the link, in one clock domain.
`timescale 1ns/1ns
module scm_link_asserts import scm_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fpga_config_clock,
   input wire logic chain_select_n,
   input wire logic program_mode_select_n,
   input wire logic data_o,
   input wire logic data_oe_n,
   input wire logic chain_pass_n,
   input wire logic ready_oe_n
);
   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   logic [5:0] por_cnt;

   // Cycles since reset release; saturates so it never wraps
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         por_cnt <= 6'h00;
      end else if (por_cnt != 6'h3f) begin
         por_cnt <= por_cnt + 6'h01;
      end
   end

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Margin of two cycles either side of the power-on count
   property p_ready_low;
      por_cnt < POR_CYC - 2 |-> !ready_oe_n;
   endproperty
   a_ready_low: assert property (p_ready_low) else $error("ready released early");

   property p_ready_up;
      por_cnt > POR_CYC + 2 |-> ready_oe_n;
   endproperty
   a_ready_up: assert property (p_ready_up) else $error("ready not released");

   property p_ready_hold;
      ready_oe_n |=> ready_oe_n;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready pulled again");

   // Synchroniser and output flop add three cycles, hence five of deselect
   property p_standby_off;
      (chain_select_n && program_mode_select_n) [*5] |-> data_oe_n;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("driver on in standby");

   property p_standby_hold;
      chain_select_n [*5] |-> $stable(data_o);
   endproperty
   a_standby_hold: assert property (p_standby_hold) else $error("data moved deselected");

   property p_prog_off;
      !program_mode_select_n [*5] |-> data_oe_n;
   endproperty
   a_prog_off: assert property (p_prog_off) else $error("driver on in programming");

   property p_step_on_clock;
      $changed(data_o) |-> $past(fpga_config_clock, 3);
   endproperty
   a_step_on_clock: assert property (p_step_on_clock) else $error("step without clock");

   property p_enable_select;
      $fell(data_oe_n) |-> !$past(chain_select_n, 2);
   endproperty
   a_enable_select: assert property (p_enable_select) else $error("driver on unselected");

   property p_pass_off;
      !chain_pass_n |-> data_oe_n;
   endproperty
   a_pass_off: assert property (p_pass_off) else $error("driver on after pass");

   c_load: cover property ($fell(data_oe_n));
   c_ready: cover property ($rose(ready_oe_n));
   c_prog: cover property ($fell(program_mode_select_n));
   c_deselect: cover property ($rose(chain_select_n));
endmodule

// ==== verification/serial_config_memory_readout_tb.sv ====
// Bench joining both ends of the link and checking the streamed bits.
// Assumes the package, interface and both design ends compile first.
`timescale 1ns/1ns
module serial_config_memory_readout_tb import scm_pkg::*; ;
   logic clk, rst_n, start, clear_at_end, gate_pol, isp_req, prog_wr, pol_wr, pol_val;
   logic rx_bit, rx_valid, busy, done, standby, prog_mode, reset_pol;
   logic [LEN_W-1:0] load_len;
   logic [BYTE_W-1:0] prog_addr, byte_addr;
   logic [BIT_W-1:0] bit_addr;
   logic [7:0] prog_data;
   logic [7:0] mem [4];
   logic exp_q [$];
   int n_mismatch, checks;

   // ------------------------------------------------------------
   // Clock and design
   // ------------------------------------------------------------
   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   scm_if u_scm_if ();
   scm_device u_scm_device (.clk(clk), .rst_n(rst_n), .link(u_scm_if.dev),
      .prog_wr(prog_wr), .prog_addr(prog_addr), .prog_data(prog_data),
      .pol_wr(pol_wr), .pol_val(pol_val), .byte_addr(byte_addr), .bit_addr(bit_addr),
      .standby(standby), .prog_mode(prog_mode), .reset_pol(reset_pol));
   scm_host u_scm_host (.clk(clk), .rst_n(rst_n), .link(u_scm_if.host), .start(start),
      .load_len(load_len), .clear_at_end(clear_at_end), .gate_pol(gate_pol),
      .isp_req(isp_req), .rx_bit(rx_bit), .rx_valid(rx_valid), .busy(busy), .done(done));
   scm_link_asserts u_scm_link_asserts (.clk(clk), .rst_n(rst_n),
      .fpga_config_clock(u_scm_if.fpga_config_clock),
      .chain_select_n(u_scm_if.chain_select_n),
      .program_mode_select_n(u_scm_if.program_mode_select_n),
      .data_o(u_scm_if.data_o), .data_oe_n(u_scm_if.data_oe_n),
      .chain_pass_n(u_scm_if.chain_pass_n), .ready_oe_n(u_scm_if.ready_oe_n));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Eight cycles let the host move the pins and the device sync them
   task automatic set_isp(input logic v);
      @(posedge clk);
      isp_req <= v;
      ticks(8);
   endtask

   // w high writes a byte, low writes the polarity from d bit 0
   task automatic prog(input logic w, input logic [BYTE_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      prog_wr <= w;
      pol_wr <= !w;
      prog_addr <= a;
      prog_data <= d;
      pol_val <= d[0];
      @(posedge clk);
      prog_wr <= 1'b0;
      pol_wr <= 1'b0;
   endtask

   // Notes the bits, runs one load, then checks the counter, cleared or held
   task automatic load(input int len, input logic clr, input logic pol);
      int i;
      for (i = 0; i < len; i++) begin
         exp_q.push_back(mem[i / 8][7 - i % 8]);
      end
      @(posedge clk);
      load_len <= LEN_W'(len);
      clear_at_end <= clr;
      gate_pol <= pol;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      ticks(2);
      cmp(16'(busy), 16'h0001);
      cmp(16'(u_scm_if.program_mode_select_n), 16'h0001);
      for (i = 0; done !== 1'b1; i++) begin
         if (i > 20 * len + 400) begin
            n_mismatch++;
            wrap_up();
         end
         @(posedge clk);
      end
      ticks(6);
      cmp({byte_addr, bit_addr}, clr ? 16'h0000 : 16'(len + 1));
      cmp(16'(standby), 16'h0001);
      cmp(16'(u_scm_if.data_line), 16'h0001);
      cmp(16'(busy), 16'h0000);
      cmp(16'(u_scm_if.chain_pass_n), 16'h0001);
   endtask

   // ------------------------------------------------------------
   // Result watcher: oldest note against each received bit
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp(16'h0001, 16'h0000);
         end else begin
            cmp(16'(rx_bit), 16'(exp_q.pop_front()));
         end
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int i;
      {clk, rst_n, start, clear_at_end, gate_pol, isp_req, prog_wr, pol_wr, pol_val} = 9'h000;
      load_len = '0;
      prog_addr = '0;
      prog_data = 8'h00;
      n_mismatch = 0;
      checks = 0;
      void'($urandom(66));
      ticks(6);
      rst_n <= 1'b1;
      ticks(2);
      cmp(16'(u_scm_if.ready_line), 16'h0000);
      ticks(POR_CYC + 4);
      cmp(16'(u_scm_if.ready_line), 16'h0001);
      // Chain select stays high here yet the writes must land
      set_isp(1'b1);
      cmp(16'(prog_mode), 16'h0001);
      cmp(16'(standby), 16'h0000);
      for (i = 0; i < 4; i++) begin
         mem[i] = 8'($urandom);
         prog(1'b1, BYTE_W'(i), mem[i]);
      end
      set_isp(1'b0);
      cmp(16'(prog_mode), 16'h0000);
      // Dropped outside programming mode; the load proves it
      prog(1'b1, 13'h0000, ~mem[0]);
      load(32, 1'b1, 1'b0);
      load(16, 1'b0, 1'b0);
      set_isp(1'b1);
      prog(1'b0, 13'h0000, 8'h01);
      set_isp(1'b0);
      cmp(16'(reset_pol), 16'h0001);
      for (i = 0; i < 3; i++) begin
         load(1 + int'($urandom % 32), i[0], 1'b1);
      end
      cmp(16'(exp_q.size()), 16'h0000);
      wrap_up();
   end
endmodule
